// file: core/b2sram_pkg.sv
// Shared constants for the burst-of-two DDR SRAM model
package b2sram_pkg;
  // ----------------------------------------
  // Configuration defaults
  // ----------------------------------------
  localparam int DATA_W_DEF = 36;
  localparam int ADDR_W_DEF = 10;
  localparam int FIFO_DEPTH_DEF = 32;
  // Lane widths: 9-bit byte lanes, 4-bit nibble lanes on the x8 part
  localparam int BYTE_LANE_W = 9;
  localparam int NIB_LANE_W = 4;
  localparam int NIB_DATA_W = 8;
  localparam int WIDE_DATA_W = 36;
  localparam int MID_DATA_W = 18;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_NOP,
    CMD_WRITE,
    CMD_READ
  } cmd_e;
endpackage

// file: core/b2sram_core.sv
// Burst-of-two common-I/O DDR SRAM core with write buffer
// Behaviour
// - Address and command sampled on positive clock rise
// - Command-valid high loads nothing, then deselects
// - Write beats follow at next edges
// - Read beats driven at rise n+2 and the negative rise after it
// - No-operation or write releases drivers one cycle
// - Termination enable signals termination only while drivers are released
// - Beat mask true if any lane low
// - Both beats masked low store both beats
// - First beat only stores first beat
// - Second beat only stores second beat
// - All masks high aborts the write
// - High mask leaves lane contents untouched
// - Four 9-bit lanes in 36-bit configuration
// - Two 9-bit lanes in 18-bit configuration
// - Second beat sampled on negative clock rise
// - Two nibble lanes in 8-bit configuration
`timescale 1ns/1ps

// ----------------------------------------
// Synchronous FIFO
// ----------------------------------------
module b2sram_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
  } fifo_s;
  fifo_s st_ff;
  fifo_s nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin
      $error("DEPTH must be a power of two");
    end
  end

  assign in_ready = !((st_ff.wr_ptr[PW] != st_ff.rd_ptr[PW]) &&
                      (st_ff.wr_ptr[PW-1:0] == st_ff.rd_ptr[PW-1:0]));
  assign out_valid = st_ff.wr_ptr != st_ff.rd_ptr;
  assign out_data = mem[st_ff.rd_ptr[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
      if (push) begin
        mem[st_ff.wr_ptr[PW-1:0]] <= in_data;
      end
    end
  end
endmodule // b2sram_fifo

// ----------------------------------------
// SRAM core
// ----------------------------------------
module b2sram_core #(
  parameter int DATA_W = b2sram_pkg::DATA_W_DEF,
  parameter int ADDR_W = b2sram_pkg::ADDR_W_DEF,
  parameter int FIFO_DEPTH = b2sram_pkg::FIFO_DEPTH_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic POS_CLK,
  input wire logic NEG_CLK,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic CMD_VALID_N,
  input wire logic READ_NOT_WRITE,
  input wire logic [DATA_W-1:0] DQ_I,
  output logic [DATA_W-1:0] DQ_O,
  output logic DQ_OE,
  input wire logic [DATA_W / ((DATA_W == b2sram_pkg::NIB_DATA_W) ?
    b2sram_pkg::NIB_LANE_W : b2sram_pkg::BYTE_LANE_W) - 1:0] LANE_WRITE_MASK_N,
  input wire logic TERMINATION_ENABLE,
  output logic DQ_TERM_ON,
  output logic DESELECTED,
  output logic WR_BUF_FULL
);
  localparam int LANE_W = (DATA_W == b2sram_pkg::NIB_DATA_W) ?
                          b2sram_pkg::NIB_LANE_W : b2sram_pkg::BYTE_LANE_W;
  localparam int MASK_W = DATA_W / LANE_W;
  localparam int ENT_W = ADDR_W + 2 * DATA_W + 2 * MASK_W;

  initial begin
    if (DATA_W != b2sram_pkg::NIB_DATA_W && DATA_W != b2sram_pkg::MID_DATA_W &&
        DATA_W != b2sram_pkg::WIDE_DATA_W) begin
      $error("DATA_W must be 8, 18 or 36");
    end
  end

  typedef struct packed {
    logic kp_s1;
    logic kp_s2;
    logic kp_d;
    logic kn_s1;
    logic kn_s2;
    logic kn_d;
    logic cv_s1;
    logic cv_s2;
    logic rw_s1;
    logic rw_s2;
    logic te_s1;
    logic te_s2;
    logic [ADDR_W-1:0] a_s1;
    logic [ADDR_W-1:0] a_s2;
    logic [DATA_W-1:0] d_s1;
    logic [DATA_W-1:0] d_s2;
    logic [MASK_W-1:0] m_s1;
    logic [MASK_W-1:0] m_s2;
    b2sram_pkg::cmd_e cmd0;
    b2sram_pkg::cmd_e cmd1;
    logic [ADDR_W-1:0] addr0;
    logic [ADDR_W-1:0] addr1;
    logic wait_b2;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] d1;
    logic [MASK_W-1:0] m1;
    logic drive_b2;
    logic [2*DATA_W-1:0] rdata;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
    logic term_on;
    logic desel;
    logic buf_full;
  } core_s;

  core_s st_ff;
  core_s nxt_st;
  logic [2*DATA_W-1:0] mem [2**ADDR_W];
  logic k_rise;
  logic kn_rise;
  logic lookup;
  logic push_valid;
  logic push_ready;
  logic [ENT_W-1:0] push_data;
  logic drain_valid;
  logic drain_ready;
  logic [ENT_W-1:0] drain_data;
  logic [ADDR_W-1:0] dr_addr;
  logic [DATA_W-1:0] dr_d1;
  logic [DATA_W-1:0] dr_d2;
  logic [MASK_W-1:0] dr_m1;
  logic [MASK_W-1:0] dr_m2;
  logic [2*DATA_W-1:0] dr_en;

  // Active-low lane masks widened to per-bit write enables
  function automatic logic [DATA_W-1:0] lane_bits(input logic [MASK_W-1:0] mask_n);
    logic [DATA_W-1:0] en;
    en = '0;
    for (int i = 0; i < DATA_W; i++) begin
      en[i] = !mask_n[i / LANE_W];
    end
    return en;
  endfunction

  assign k_rise = st_ff.kp_s2 && !st_ff.kp_d;
  assign kn_rise = st_ff.kn_s2 && !st_ff.kn_d;
  assign lookup = kn_rise && (st_ff.cmd1 == b2sram_pkg::CMD_READ);
  // beat true on any low mask
  assign push_valid = kn_rise && st_ff.wait_b2 && (!(&st_ff.m1) || !(&st_ff.m_s2));
  assign push_data = {st_ff.wr_addr, st_ff.d1, st_ff.d_s2, st_ff.m1, st_ff.m_s2};
  // Drain waits while a read looks up, so lookup and store never collide
  assign drain_ready = !lookup;
  assign {dr_addr, dr_d1, dr_d2, dr_m1, dr_m2} = drain_data;
  // lane k gates bits k*9 up to k*9+8
  // two 9-bit lanes on the 18-bit part
  // nibble lanes on the 8-bit part
  assign dr_en = {lane_bits(dr_m2), lane_bits(dr_m1)};

  b2sram_fifo #(
    .WIDTH(ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_data)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.kp_s1 = POS_CLK;
    nxt_st.kp_s2 = st_ff.kp_s1;
    nxt_st.kp_d = st_ff.kp_s2;
    nxt_st.kn_s1 = NEG_CLK;
    nxt_st.kn_s2 = st_ff.kn_s1;
    nxt_st.kn_d = st_ff.kn_s2;
    nxt_st.cv_s1 = CMD_VALID_N;
    nxt_st.cv_s2 = st_ff.cv_s1;
    nxt_st.rw_s1 = READ_NOT_WRITE;
    nxt_st.rw_s2 = st_ff.rw_s1;
    nxt_st.te_s1 = TERMINATION_ENABLE;
    nxt_st.te_s2 = st_ff.te_s1;
    nxt_st.a_s1 = ADDR;
    nxt_st.a_s2 = st_ff.a_s1;
    nxt_st.d_s1 = DQ_I;
    nxt_st.d_s2 = st_ff.d_s1;
    nxt_st.m_s1 = LANE_WRITE_MASK_N;
    nxt_st.m_s2 = st_ff.m_s1;
    if (k_rise) begin
      // first write beat on the next rise
      if (st_ff.cmd0 == b2sram_pkg::CMD_WRITE) begin
        nxt_st.wait_b2 = 1'b1;
        nxt_st.wr_addr = st_ff.addr0;
        nxt_st.d1 = st_ff.d_s2;
        nxt_st.m1 = st_ff.m_s2;
      end
      // first read beat two rises on
      if (st_ff.cmd1 == b2sram_pkg::CMD_READ) begin
        nxt_st.dq_o = st_ff.rdata[DATA_W-1:0];
        nxt_st.dq_oe = 1'b1;
        nxt_st.drive_b2 = 1'b1;
      end else begin
        nxt_st.drive_b2 = 1'b0;
      end
      // command taken only on the rise
      if (st_ff.cv_s2) begin
        nxt_st.cmd0 = b2sram_pkg::CMD_NOP;
      end else if (st_ff.rw_s2) begin
        nxt_st.cmd0 = b2sram_pkg::CMD_READ;
      end else begin
        nxt_st.cmd0 = b2sram_pkg::CMD_WRITE;
      end
      nxt_st.addr0 = st_ff.a_s2;
      nxt_st.cmd1 = st_ff.cmd0;
      nxt_st.addr1 = st_ff.addr0;
    end
    if (kn_rise) begin
      // second beat on the negative clock rise
      if (st_ff.wait_b2) begin
        nxt_st.wait_b2 = 1'b0;
      end
      if (lookup) begin
        nxt_st.rdata = mem[st_ff.addr1];
      end
      // second read beat half a cycle on
      if (st_ff.drive_b2) begin
        nxt_st.dq_o = st_ff.rdata[2*DATA_W-1:DATA_W];
        nxt_st.dq_oe = 1'b1;
        nxt_st.drive_b2 = 1'b0;
      end else begin
        nxt_st.dq_oe = 1'b0;
      end
    end
    nxt_st.term_on = st_ff.te_s2 && !nxt_st.dq_oe;
    // deselected once no burst is outstanding
    nxt_st.desel = !nxt_st.dq_oe && !nxt_st.wait_b2 && !nxt_st.drive_b2 &&
                   (nxt_st.cmd0 == b2sram_pkg::CMD_NOP) &&
                   (nxt_st.cmd1 == b2sram_pkg::CMD_NOP);
    nxt_st.buf_full = !push_ready;
  end

  // ----------------------------------------
  // Registers and array
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_ff <= '0;
    end else if (CE) begin
      st_ff <= nxt_st;
    end
  end

  // second half kept when only first enabled
  // first half kept when only second enabled
  // high mask keeps the old lane
  always_ff @(posedge CLK_SYS) begin
    if (CE && drain_valid && drain_ready) begin
      mem[dr_addr] <= (mem[dr_addr] & ~dr_en) | ({dr_d2, dr_d1} & dr_en);
    end
  end

  assign DQ_O = st_ff.dq_o;
  assign DQ_OE = st_ff.dq_oe;
  assign DQ_TERM_ON = st_ff.term_on;
  assign DESELECTED = st_ff.desel;
  assign WR_BUF_FULL = st_ff.buf_full;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_cmd_on_rise: assert property (CE && !k_rise |=> $stable(st_ff.cmd0))
    else $error("command changed without a clock rise");
  a_desel_no_load: assert property (CE && k_rise && st_ff.cv_s2 |=>
    st_ff.cmd0 == b2sram_pkg::CMD_NOP)
    else $error("command loaded while command-valid high");
  a_write_beat_one: assert property (CE && k_rise &&
    st_ff.cmd0 == b2sram_pkg::CMD_WRITE |=> st_ff.wait_b2 && st_ff.d1 == $past(st_ff.d_s2))
    else $error("first write beat not captured");
  a_read_beat_one: assert property (CE && k_rise &&
    st_ff.cmd1 == b2sram_pkg::CMD_READ |=> DQ_OE && DQ_O == $past(st_ff.rdata[DATA_W-1:0]))
    else $error("first read beat missing");
  a_read_beat_two: assert property (CE && kn_rise && st_ff.drive_b2 |=>
    DQ_OE && DQ_O == $past(st_ff.rdata[2*DATA_W-1:DATA_W]))
    else $error("second read beat missing");
  a_release_drv: assert property (CE && kn_rise && !st_ff.drive_b2 |=> !DQ_OE)
    else $error("drivers not released after no-operation or write");
  a_term_follow: assert property (CE && st_ff.te_s2 ##1 !DQ_OE |-> DQ_TERM_ON)
    else $error("termination not shown on released pins");
  a_abort_write: assert property (CE && drain_valid && drain_ready |->
    !(&dr_m1) || !(&dr_m2))
    else $error("aborted write was queued");
  a_full_flag: assert property (CE && !push_ready |=> WR_BUF_FULL)
    else $error("buffer full not reported");

  c_write: cover property (CE && push_valid && push_ready);
  c_read: cover property (CE && k_rise && st_ff.cmd1 == b2sram_pkg::CMD_READ);
  c_abort: cover property (CE && kn_rise && st_ff.wait_b2 && !push_valid);
  c_desel: cover property (DESELECTED ##1 !DESELECTED);
endmodule // b2sram_core

// file: tb/b2sram_ctl_model.sv
// Controller model: drives both SRAM clocks, commands, write beats and the shared bus
`timescale 1ns/1ps
module b2sram_ctl_model (
  input wire logic clk,
  input wire logic [35:0] dq_o,
  input wire logic dq_oe,
  output logic pos_clk,
  output logic neg_clk,
  output logic [9:0] addr,
  output logic vld_n,
  output logic rnw,
  output logic [3:0] mask_n,
  output wire logic [35:0] dq_i
);
  logic [35:0] drv;
  logic den;
  logic [35:0] qa;
  logic [35:0] qb;
  logic oa;
  logic ob;
  // Released bus shows the inverse of the current drive word drv, so stale data cannot match
  assign dq_i = dq_oe ? dq_o : (den ? drv : ~drv);
  initial begin
    pos_clk = 1'b0;
    neg_clk = 1'b1;
    addr = 10'h000;
    vld_n = 1'b1;
    rnw = 1'b0;
    mask_n = 4'hf;
    drv = 36'h000000000;
    den = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // command and address held across the positive rise, inverted for the negative rise
  task automatic kcyc(input logic v, input logic r, input logic [9:0] a,
    input logic [35:0] d1, input logic [3:0] m1, input logic [35:0] d2,
    input logic [3:0] m2, input logic e);
    vld_n = v;
    rnw = r;
    addr = a;
    drv = d1;
    mask_n = m1;
    den = e;
    wt(2);
    pos_clk = 1'b1;
    neg_clk = 1'b0;
    wt(2);
    qa = dq_o;
    oa = dq_oe;
    vld_n = ~v;
    rnw = ~r;
    addr = ~a;
    drv = d2;
    mask_n = m2;
    wt(2);
    pos_clk = 1'b0;
    neg_clk = 1'b1;
    wt(2);
    qb = dq_o;
    ob = dq_oe;
  endtask
endmodule // b2sram_ctl_model

// file: tb/tb_ddr_burst2_sram_cmd_write_mask.sv
// Self-checking bench for the burst-of-two SRAM core
`timescale 1ns/1ps
module tb_ddr_burst2_sram_cmd_write_mask;
  logic clk;
  logic rst;
  logic term;
  logic pk;
  logic nk;
  logic vn;
  logic rnw;
  logic oe;
  logic term_on;
  logic desel;
  logic full;
  logic [9:0] addr;
  logic [3:0] mask;
  logic [35:0] dqi;
  logic [35:0] dqo;
  logic [35:0] q1;
  logic [35:0] q2;
  logic [17:0] dqo_mid;
  logic [17:0] q1_mid;
  logic [17:0] q2_mid;
  logic [7:0] dqo_nib;
  logic [7:0] q1_nib;
  logic [7:0] q2_nib;
  int errors;
  int samples_checked;
  int cyc;
  // ----------------------------------------
  // Design and controller
  // ----------------------------------------
  b2sram_core #(.DATA_W(36), .ADDR_W(10), .FIFO_DEPTH(32)) u_dut (
    .CLK_SYS(clk), .RST(rst), .CE(1'b1), .POS_CLK(pk), .NEG_CLK(nk),
    .ADDR(addr), .CMD_VALID_N(vn), .READ_NOT_WRITE(rnw), .DQ_I(dqi),
    .DQ_O(dqo), .DQ_OE(oe), .LANE_WRITE_MASK_N(mask),
    .TERMINATION_ENABLE(term), .DQ_TERM_ON(term_on), .DESELECTED(desel),
    .WR_BUF_FULL(full)
  );
  b2sram_ctl_model u_ctl (
    .clk(clk), .dq_o(dqo), .dq_oe(oe), .pos_clk(pk), .neg_clk(nk),
    .addr(addr), .vld_n(vn), .rnw(rnw), .mask_n(mask), .dq_i(dqi)
  );
  // Narrow parts run in lockstep on bus slices; the wide part owns the loopback
  b2sram_core #(.DATA_W(18), .ADDR_W(10), .FIFO_DEPTH(32)) u_dut_mid (
    .CLK_SYS(clk), .RST(rst), .CE(1'b1), .POS_CLK(pk), .NEG_CLK(nk),
    .ADDR(addr), .CMD_VALID_N(vn), .READ_NOT_WRITE(rnw), .DQ_I(dqi[17:0]),
    .DQ_O(dqo_mid), .DQ_OE(), .LANE_WRITE_MASK_N(mask[1:0]),
    .TERMINATION_ENABLE(term), .DQ_TERM_ON(), .DESELECTED(),
    .WR_BUF_FULL()
  );
  b2sram_core #(.DATA_W(8), .ADDR_W(10), .FIFO_DEPTH(32)) u_dut_nib (
    .CLK_SYS(clk), .RST(rst), .CE(1'b1), .POS_CLK(pk), .NEG_CLK(nk),
    .ADDR(addr), .CMD_VALID_N(vn), .READ_NOT_WRITE(rnw), .DQ_I(dqi[7:0]),
    .DQ_O(dqo_nib), .DQ_OE(), .LANE_WRITE_MASK_N(mask[1:0]),
    .TERMINATION_ENABLE(term), .DQ_TERM_ON(), .DESELECTED(),
    .WR_BUF_FULL()
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] d,
    input logic [3:0] m);
    mrg = o;
    for (int i = 0; i < 4; i++) if (!m[i]) mrg[i*9 +: 9] = d[i*9 +: 9];
  endfunction
  function automatic logic [7:0] mrg_nib(input logic [7:0] o, input logic [7:0] d,
    input logic [1:0] m);
    mrg_nib = o;
    for (int i = 0; i < 2; i++) if (!m[i]) mrg_nib[i*4 +: 4] = d[i*4 +: 4];
  endfunction
  task automatic idle(input int n);
    repeat (n) u_ctl.kcyc(1'b1, 1'b0, 10'h000, '0, 4'hf, '0, 4'hf, 1'b0);
  endtask
  task automatic wr(input logic [9:0] a, input logic [35:0] d1, input logic [3:0] m1,
    input logic [35:0] d2, input logic [3:0] m2);
    u_ctl.kcyc(1'b0, 1'b0, a, '0, 4'hf, '0, 4'hf, 1'b0);
    u_ctl.kcyc(1'b1, 1'b0, 10'h000, d1, m1, d2, m2, 1'b1);
  endtask
  task automatic rd(input logic [9:0] a);
    u_ctl.kcyc(1'b0, 1'b1, a, '0, 4'hf, '0, 4'hf, 1'b0);
    idle(1);
    chk("deselected mid burst", desel, 1'b0);
    idle(1);
    q1 = u_ctl.qb;
    q1_mid = dqo_mid;
    q1_nib = dqo_nib;
    chk("oe beat1", u_ctl.ob, 1'b1);
    idle(1);
    q2 = u_ctl.qa;
    // A non-read slot leaves the data word alone, so beat two still stands here
    q2_mid = dqo_mid;
    q2_nib = dqo_nib;
    chk("oe beat2", u_ctl.oa, 1'b1);
    idle(1);
    chk("oe after burst", u_ctl.oa, 1'b0);
    chk("term flag", term_on, term);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_basic();
    wr(10'h005, 36'h123456789, 4'h0, 36'h9abcdef01, 4'h0);
    rd(10'h005);
    chk("beat1", q1, 36'h123456789);
    chk("beat2", q2, 36'h9abcdef01);
    chk("buffer full", full, 1'b0);
  endtask
  task automatic t_abort();
    idle(3);
    chk("deselected idle", desel, 1'b1);
    wr(10'h00a, 36'h0f0f0f0f0, 4'h0, 36'h3c3c3c3c3, 4'h0);
    wr(10'h00a, 36'hfffffffff, 4'hf, 36'h000000000, 4'hf);
    idle(2);
    chk("oe after write", u_ctl.oa, 1'b0);
    rd(10'h00a);
    chk("abort beat1", q1, 36'h0f0f0f0f0);
    chk("abort beat2", q2, 36'h3c3c3c3c3);
  endtask
  task automatic t_masks();
    logic [3:0] m;
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      wr(10'h100 + i[9:0], 36'h123456789, 4'h0, 36'h9abcdef01, 4'h0);
      wr(10'h100 + i[9:0], 36'hedcba9876, m, 36'h6543210fe, ~m);
      rd(10'h100 + i[9:0]);
      chk("lanes beat1", q1, mrg(36'h123456789, 36'hedcba9876, m));
      chk("lanes beat2", q2, mrg(36'h9abcdef01, 36'h6543210fe, ~m));
      chk("mid beat1", {18'h00000, q1_mid},
        mrg(36'h123456789, 36'hedcba9876, m) & 36'h00003ffff);
      chk("mid beat2", {18'h00000, q2_mid},
        mrg(36'h9abcdef01, 36'h6543210fe, ~m) & 36'h00003ffff);
      chk("nib beat1", {28'h0000000, q1_nib},
        {28'h0000000, mrg_nib(8'h89, 8'h76, m[1:0])});
      chk("nib beat2", {28'h0000000, q2_nib},
        {28'h0000000, mrg_nib(8'h01, 8'hfe, ~m[1:0])});
    end
  endtask
  // ----------------------------------------
  // Clock, reset, sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Ceiling well above the roughly 1340 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    term = 1'b0;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_basic();
    term = 1'b1;
    t_abort();
    t_masks();
    close_out();
  end
endmodule // tb_ddr_burst2_sram_cmd_write_mask
